// ### cnsi_node.sv
// Overview of operation
// - Temperature via temperature PDO or index 3200.
// - Reply 4Bh, echo index, temperature low first.
// - Setup only if selector 00 within 10s.
// - Setup results stored in non-volatile memory.
// - Blink three indicators 1Hz, 5s rate window.
// - Selector 00..08 decodes to nine bit rates.
// - Commit bit rate when rate window ends.
// - Then only run indicator keeps blinking.
// - Accept node number 01..63 in 5s.
// - Adopt node number, enter pre-operational operation.
// - Written bit rate applies after next reset.
// - Identifier is function code plus node, except NMT and SYNC.
// - Identifier word: length, data flag, node bits.
// - Data flag zero means request without data.
// - Provide PDOs, two config channels, monitoring.
// - Fixed identifiers per object type.
// - PDOs handled only in operational state.
`timescale 1ns/10ps
`include "cnsi_defs.svh"

module cnsi_node #(
    parameter int unsigned POWERUP_CYCLES = 32'(`CNSI_POWERUP_CYCLES),
    parameter int unsigned SETUP_CYCLES = 32'(`CNSI_SETUP_CYCLES),
    parameter int unsigned BLINK_HALF_CYCLES = 32'(`CNSI_BLINK_HALF_CYCLES)
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Address selector and stored settings
    input wire logic [6:0] addrSelector,
    input wire logic [3:0] nvmBitRate,
    input wire logic [6:0] nvmNodeNumber,
    // Non-volatile memory write strobes
    output logic nvmRateWe,
    output logic [3:0] nvmRateData,
    output logic nvmIdWe,
    output logic [6:0] nvmIdData,
    // Active settings and status
    output cnsi_pkg::cnsi_rate_t bitRate,
    output logic [6:0] nodeNumber,
    output logic nodeRunning,
    input wire logic nmtOperational,
    // Indicators
    output logic errorIndicator,
    output logic runIndicator,
    output logic busActiveIndicator,
    // Temperature and event inputs
    input wire logic [15:0] tempCentiC,
    input wire logic tempPdoReq,
    input wire logic emcyReq,
    input wire logic [15:0] emcyCode,
    // Received frames
    input wire logic rxValid,
    output logic rxReady,
    input wire logic [10:0] rxCobId,
    input wire logic rxDataFlag,
    input wire logic [3:0] rxDlc,
    input wire logic [63:0] rxData,
    // Frames to send
    output logic txValid,
    input wire logic txReady,
    output logic [10:0] txCobId,
    output logic txDataFlag,
    output logic [3:0] txDlc,
    output logic [63:0] txData,
    output logic [15:0] txIdWord
);

    cnsi_pkg::cnsi_setup_t state;
    cnsi_pkg::cnsi_setup_t next_state;
    cnsi_pkg::cnsi_rate_t next_bitRate;
    cnsi_pkg::cnsi_obj_t rxObj;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [6:0] next_nodeNumber;
    logic next_nvmRateWe;
    logic [3:0] next_nvmRateData;
    logic next_nvmIdWe;
    logic [6:0] next_nvmIdData;
    logic next_errorIndicator;
    logic next_runIndicator;
    logic next_busActiveIndicator;
    logic blink;
    logic blinkRun;
    logic sdoRateWr;
    logic [3:0] sdoRateVal;
    logic [15:0] tempReg;
    logic tempPending;
    logic next_tempPending;
    logic emcyPending;
    logic next_emcyPending;
    logic [15:0] emcyCodeReg;
    logic [15:0] next_emcyCodeReg;
    logic next_txValid;
    logic [10:0] next_txCobId;
    logic next_txDataFlag;
    logic [3:0] next_txDlc;
    logic [63:0] next_txData;
    logic rxFire;
    logic [10:0] nodeExt;
    logic [7:0] rxCmd;
    logic [15:0] rxIndex;
    logic [7:0] rxSub;
    logic [10:0] cfgReplyId;

    assign blinkRun = (state == cnsi_pkg::CNSI_ST_RATE) || (state == cnsi_pkg::CNSI_ST_ID);
    assign nodeRunning = (state == cnsi_pkg::CNSI_ST_RUN);
    assign rxReady = nodeRunning && !txValid;
    assign rxFire = rxValid && rxReady;
    assign nodeExt = {4'h0, nodeNumber};
    assign rxCmd = rxData[7:0];
    assign rxIndex = rxData[23:8];
    assign rxSub = rxData[31:24];
    assign cfgReplyId = (rxObj == cnsi_pkg::CNSI_OBJ_CFG2) ?
        11'(`CNSI_FC_CFG2_REPLY + nodeExt) : 11'(`CNSI_FC_CFG1_REPLY + nodeExt);
    // Length, data flag and node bits.
    assign txIdWord = {txCobId[10:3], nodeNumber[2:0], txDataFlag, txDlc};

    cnsi_blink #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .run(blinkRun),
        .blink(blink)
    );

    cnsi_cob_decode u_decode (
        .cobId(rxCobId),
        .node(nodeNumber),
        .obj(rxObj)
    );

    // Setup procedure, active settings and indicators.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bitRate = bitRate;
        next_nodeNumber = nodeNumber;
        next_nvmRateWe = 1'b0;
        next_nvmRateData = nvmRateData;
        next_nvmIdWe = 1'b0;
        next_nvmIdData = nvmIdData;
        next_errorIndicator = 1'b0;
        next_runIndicator = 1'b0;
        next_busActiveIndicator = 1'b0;
        case (state)
            cnsi_pkg::CNSI_ST_CHECK: begin
                // Stored settings are taken while waiting, never under reset.
                next_bitRate = cnsi_pkg::cnsi_rate_t'(nvmBitRate);
                next_nodeNumber = nvmNodeNumber;
                next_cnt = cnt + 32'd1;
                if (addrSelector == `CNSI_SEL_SETUP) begin
                    next_state = cnsi_pkg::CNSI_ST_RATE;
                    next_cnt = 32'h0;
                end else if (cnt == POWERUP_CYCLES - 32'd1) begin
                    next_state = cnsi_pkg::CNSI_ST_RUN;
                    next_cnt = 32'h0;
                end
            end
            cnsi_pkg::CNSI_ST_RATE: begin
                next_errorIndicator = blink;
                next_runIndicator = blink;
                next_busActiveIndicator = blink;
                next_cnt = cnt + 32'd1;
                if (cnt == SETUP_CYCLES - 32'd1) begin
                    if (addrSelector <= `CNSI_SEL_RATE_MAX) begin
                        next_bitRate = cnsi_pkg::cnsi_rate_t'(addrSelector[3:0]);
                    end
                    next_nvmRateWe = 1'b1;
                    next_nvmRateData = next_bitRate;
                    next_state = cnsi_pkg::CNSI_ST_ID;
                    next_cnt = 32'h0;
                end
            end
            cnsi_pkg::CNSI_ST_ID: begin
                next_runIndicator = blink;
                next_cnt = cnt + 32'd1;
                if (cnt == SETUP_CYCLES - 32'd1) begin
                    if (addrSelector >= `CNSI_SEL_ID_MIN && addrSelector <= `CNSI_SEL_ID_MAX) begin
                        next_nodeNumber = addrSelector;
                        next_nvmIdWe = 1'b1;
                        next_nvmIdData = addrSelector;
                    end
                    next_state = cnsi_pkg::CNSI_ST_RUN;
                    next_cnt = 32'h0;
                end
            end
            cnsi_pkg::CNSI_ST_RUN: begin
                next_runIndicator = 1'b1;
                next_busActiveIndicator = rxFire || txValid;
                if (sdoRateWr) begin
                    next_nvmRateWe = 1'b1;
                    next_nvmRateData = sdoRateVal;
                end
            end
            default: begin
                next_state = cnsi_pkg::CNSI_ST_CHECK;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= cnsi_pkg::CNSI_ST_CHECK;
            cnt <= 32'h0;
            bitRate <= cnsi_pkg::CNSI_RATE_1M;
            nodeNumber <= 7'h00;
            nvmRateWe <= 1'b0;
            nvmRateData <= 4'h0;
            nvmIdWe <= 1'b0;
            nvmIdData <= 7'h00;
            errorIndicator <= 1'b0;
            runIndicator <= 1'b0;
            busActiveIndicator <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            cnt <= next_cnt;
            bitRate <= next_bitRate;
            nodeNumber <= next_nodeNumber;
            nvmRateWe <= next_nvmRateWe;
            nvmRateData <= next_nvmRateData;
            nvmIdWe <= next_nvmIdWe;
            nvmIdData <= next_nvmIdData;
            errorIndicator <= next_errorIndicator;
            runIndicator <= next_runIndicator;
            busActiveIndicator <= next_busActiveIndicator;
        end
    end

    // Frame responder. A frame is only taken while the send slot is
    // empty, so a reply can never be lost to back-pressure.
    always_comb begin
        next_txValid = txValid && !txReady;
        next_txCobId = txCobId;
        next_txDataFlag = txDataFlag;
        next_txDlc = txDlc;
        next_txData = txData;
        next_tempPending = tempPending;
        next_emcyPending = emcyPending;
        next_emcyCodeReg = emcyCodeReg;
        sdoRateWr = 1'b0;
        sdoRateVal = rxData[35:32];
        if (!txValid && rxFire) begin
            // Flag one marks a data frame.
            next_txDataFlag = 1'b1;
            next_txDlc = `CNSI_DLC_FULL;
            next_txCobId = cfgReplyId;
            if (rxObj == cnsi_pkg::CNSI_OBJ_CFG1 || rxObj == cnsi_pkg::CNSI_OBJ_CFG2) begin
                next_txValid = 1'b1;
                next_txData = {32'(`CNSI_ABORT_NO_OBJ), rxSub, rxIndex, `CNSI_CMD_ABORT};
                if (rxCmd == `CNSI_CMD_READ && rxIndex == `CNSI_IDX_TEMP &&
                    rxSub == `CNSI_SUB_ZERO) begin
                    next_txData = {16'h0000, tempReg, rxSub, rxIndex, `CNSI_CMD_READ_REPLY2};
                end else if (rxCmd[7:5] == `CNSI_CMD_WRITE_CLASS && rxIndex == `CNSI_IDX_RATE) begin
                    if (rxData[39:32] <= 8'(`CNSI_SEL_RATE_MAX)) begin
                        sdoRateWr = 1'b1;
                        next_txData = {32'h0, rxSub, rxIndex, `CNSI_CMD_WRITE_ACK};
                    end else begin
                        next_txData = {32'(`CNSI_ABORT_RANGE), rxSub, rxIndex, `CNSI_CMD_ABORT};
                    end
                end else if (rxIndex == `CNSI_IDX_TEMP || rxIndex == `CNSI_IDX_RATE) begin
                    next_txData = {32'(`CNSI_ABORT_CMD), rxSub, rxIndex, `CNSI_CMD_ABORT};
                end
            end else if (rxObj == cnsi_pkg::CNSI_OBJ_MONITOR && !rxDataFlag) begin
                next_txValid = 1'b1;
                next_txCobId = 11'(`CNSI_FC_MONITOR + nodeExt);
                next_txDlc = `CNSI_DLC_GUARD;
                next_txData = {56'h0, nmtOperational ? `CNSI_NMT_OPER : `CNSI_NMT_PREOP};
            end else if (rxObj == cnsi_pkg::CNSI_OBJ_TEMP_TX && !rxDataFlag && nmtOperational) begin
                next_tempPending = 1'b1;
            end
        end else if (!txValid && emcyPending) begin
            next_txValid = 1'b1;
            next_txCobId = 11'(`CNSI_FC_EMCY + nodeExt);
            next_txDataFlag = 1'b1;
            next_txDlc = `CNSI_DLC_FULL;
            next_txData = {48'h0, emcyCodeReg};
            next_emcyPending = 1'b0;
        end else if (!txValid && tempPending && nmtOperational && nodeRunning) begin
            next_txValid = 1'b1;
            next_txCobId = 11'(`CNSI_FC_TEMP_TX + nodeExt);
            next_txDataFlag = 1'b1;
            next_txDlc = `CNSI_DLC_TEMP;
            next_txData = {48'h0, tempReg};
            next_tempPending = 1'b0;
        end
        // New events win over a clear in the same cycle.
        if (tempPdoReq && nmtOperational) begin
            next_tempPending = 1'b1;
        end
        if (emcyReq) begin
            next_emcyPending = 1'b1;
            next_emcyCodeReg = emcyCode;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txValid <= 1'b0;
            txCobId <= 11'h000;
            txDataFlag <= 1'b0;
            txDlc <= 4'h0;
            txData <= 64'h0;
            tempReg <= 16'h0000;
            tempPending <= 1'b0;
            emcyPending <= 1'b0;
            emcyCodeReg <= 16'h0000;
        end else if (clkEn) begin
            txValid <= next_txValid;
            txCobId <= next_txCobId;
            txDataFlag <= next_txDataFlag;
            txDlc <= next_txDlc;
            txData <= next_txData;
            tempReg <= tempCentiC;
            tempPending <= next_tempPending;
            emcyPending <= next_emcyPending;
            emcyCodeReg <= next_emcyCodeReg;
        end
    end

endmodule // cnsi_node

// ### cnsi_defs.svh
`ifndef CNSI_DEFS_SVH
`define CNSI_DEFS_SVH

// Core clock rate and the timing figures in seconds and hertz.
`define CNSI_CLK_HZ 64'd250000000
`define CNSI_POWERUP_WIN_S 64'd10
`define CNSI_SETUP_WIN_S 64'd5
`define CNSI_BLINK_HZ 64'd1
`define CNSI_POWERUP_CYCLES (`CNSI_CLK_HZ * `CNSI_POWERUP_WIN_S)
`define CNSI_SETUP_CYCLES (`CNSI_CLK_HZ * `CNSI_SETUP_WIN_S)
`define CNSI_BLINK_HALF_CYCLES (`CNSI_CLK_HZ / (64'd2 * `CNSI_BLINK_HZ))

// Selector values used by the setup procedure.
`define CNSI_SEL_SETUP 7'h00
`define CNSI_SEL_RATE_MAX 7'h08
`define CNSI_SEL_ID_MIN 7'h01
`define CNSI_SEL_ID_MAX 7'h3F

// Function codes, added to the node number to form a message identifier; NMT and SYNC are used alone.
`define CNSI_FC_NMT 11'h000
`define CNSI_FC_SYNC 11'h080
`define CNSI_FC_EMCY 11'h080
`define CNSI_FC_CLOCK_TX 11'h180
`define CNSI_FC_CLOCK_SET_RX 11'h200
`define CNSI_FC_TEMP_TX 11'h280
`define CNSI_FC_GPS_TX 11'h380
`define CNSI_FC_CFG1_REPLY 11'h580
`define CNSI_FC_CFG2_REPLY 11'h5C0
`define CNSI_FC_CFG1_REQ 11'h600
`define CNSI_FC_CFG2_REQ 11'h640
`define CNSI_FC_MONITOR 11'h700

// Configuration transfer commands, objects and abort codes.
`define CNSI_CMD_READ 8'h40
`define CNSI_CMD_READ_REPLY2 8'h4B
`define CNSI_CMD_WRITE_ACK 8'h60
`define CNSI_CMD_ABORT 8'h80
`define CNSI_CMD_WRITE_CLASS 3'h1
`define CNSI_IDX_TEMP 16'h3200
`define CNSI_IDX_RATE 16'h2001
`define CNSI_SUB_ZERO 8'h00
`define CNSI_ABORT_NO_OBJ 32'h06020000
`define CNSI_ABORT_RANGE 32'h06090030
`define CNSI_ABORT_CMD 32'h05040001

// Network state bytes returned to node guarding.
`define CNSI_NMT_PREOP 8'h7F
`define CNSI_NMT_OPER 8'h05

// Frame lengths.
`define CNSI_DLC_FULL 4'h8
`define CNSI_DLC_TEMP 4'h2
`define CNSI_DLC_GUARD 4'h1

`endif

// ### cnsi_pkg.sv
package cnsi_pkg;

    typedef enum logic [1:0] {
        CNSI_ST_CHECK = 2'b00,
        CNSI_ST_RATE = 2'b01,
        CNSI_ST_ID = 2'b10,
        CNSI_ST_RUN = 2'b11
    } cnsi_setup_t;

    typedef enum logic [3:0] {
        CNSI_RATE_1M = 4'b0000,
        CNSI_RATE_500K = 4'b0001,
        CNSI_RATE_250K = 4'b0010,
        CNSI_RATE_125K = 4'b0011,
        CNSI_RATE_100K = 4'b0100,
        CNSI_RATE_50K = 4'b0101,
        CNSI_RATE_20K = 4'b0110,
        CNSI_RATE_10K = 4'b0111,
        CNSI_RATE_800K = 4'b1000
    } cnsi_rate_t;

    typedef enum logic [3:0] {
        CNSI_OBJ_NONE = 4'b0000,
        CNSI_OBJ_NMT = 4'b0001,
        CNSI_OBJ_SYNC = 4'b0010,
        CNSI_OBJ_CLOCK_TX = 4'b0011,
        CNSI_OBJ_TEMP_TX = 4'b0100,
        CNSI_OBJ_GPS_TX = 4'b0101,
        CNSI_OBJ_CLOCK_SET = 4'b0110,
        CNSI_OBJ_CFG1 = 4'b0111,
        CNSI_OBJ_CFG2 = 4'b1000,
        CNSI_OBJ_MONITOR = 4'b1001
    } cnsi_obj_t;

endpackage

// ### cnsi_cob_decode.sv
`timescale 1ns/10ps
`include "cnsi_defs.svh"

module cnsi_cob_decode (
    // Received identifier and own node number
    input wire logic [10:0] cobId,
    input wire logic [6:0] node,
    // Object class addressed by the identifier
    output cnsi_pkg::cnsi_obj_t obj
);

    logic [10:0] nodeExt;

    assign nodeExt = {4'h0, node};

    always_comb begin
        if (cobId == `CNSI_FC_NMT) begin
            obj = cnsi_pkg::CNSI_OBJ_NMT;
        end else if (cobId == `CNSI_FC_SYNC) begin
            obj = cnsi_pkg::CNSI_OBJ_SYNC;
        end else if (cobId == 11'(`CNSI_FC_CLOCK_TX + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_CLOCK_TX;
        end else if (cobId == 11'(`CNSI_FC_TEMP_TX + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_TEMP_TX;
        end else if (cobId == 11'(`CNSI_FC_GPS_TX + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_GPS_TX;
        end else if (cobId == 11'(`CNSI_FC_CLOCK_SET_RX + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_CLOCK_SET;
        end else if (cobId == 11'(`CNSI_FC_CFG1_REQ + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_CFG1;
        end else if (cobId == 11'(`CNSI_FC_CFG2_REQ + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_CFG2;
        end else if (cobId == 11'(`CNSI_FC_MONITOR + nodeExt)) begin
            obj = cnsi_pkg::CNSI_OBJ_MONITOR;
        end else begin
            obj = cnsi_pkg::CNSI_OBJ_NONE;
        end
    end

endmodule // cnsi_cob_decode

// ### cnsi_blink.sv
`timescale 1ns/10ps

module cnsi_blink #(
    parameter int unsigned HALF_CYCLES = 32'd125000000
) (
    // Clock and control
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic run,
    // Square wave, high for the first half period after run rises
    output logic blink
);

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_blink;

    always_comb begin
        next_cnt = cnt;
        next_blink = blink;
        if (!run) begin
            next_cnt = 32'h0;
            next_blink = 1'b1;
        end else if (cnt == HALF_CYCLES - 32'd1) begin
            next_cnt = 32'h0;
            next_blink = ~blink;
        end else begin
            next_cnt = cnt + 32'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= 32'h0;
            blink <= 1'b0;
        end else if (clkEn) begin
            cnt <= next_cnt;
            blink <= next_blink;
        end
    end

endmodule // cnsi_blink

// ### cnsi_node_asserts.sv
`timescale 1ns/10ps

module cnsi_node_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Received frames
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic [10:0] rxCobId,
    input wire logic rxDataFlag,
    // Frames to send
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [10:0] txCobId,
    input wire logic txDataFlag,
    input wire logic [3:0] txDlc,
    input wire logic [63:0] txData,
    input wire logic [15:0] txIdWord,
    // Settings and status
    input wire logic [6:0] nodeNumber,
    input wire logic nodeRunning,
    input wire cnsi_pkg::cnsi_rate_t bitRate,
    input wire logic nvmRateWe,
    input wire logic [3:0] nvmRateData,
    input wire logic nvmIdWe,
    input wire logic [6:0] nvmIdData,
    // Indicators
    input wire logic errorIndicator,
    input wire logic runIndicator,
    input wire logic busActiveIndicator
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [10:0] node11;
    logic take;
    assign node11 = {4'h0, nodeNumber};
    assign take = rxValid && rxReady && clkEn && rxDataFlag;

    property p_cfg1; take && rxCobId == 11'h600 + node11
        |=> txValid && txCobId == 11'h580 + node11; endproperty
    a_cfg1: assert property (p_cfg1) else $error("first reply wrong");
    property p_cfg2; take && rxCobId == 11'h640 + node11
        |=> txValid && txCobId == 11'h5C0 + node11; endproperty
    a_cfg2: assert property (p_cfg2) else $error("second reply wrong");
    property p_idw; txValid
        |-> txIdWord == {txCobId[10:3], nodeNumber[2:0], txDataFlag, txDlc}; endproperty
    a_idw: assert property (p_idw) else $error("identifier word wrong");
    property p_hold; txValid && !txReady
        |=> txValid && $stable(txData) && $stable(txCobId); endproperty
    a_hold: assert property (p_hold) else $error("frame not held");
    property p_rate; nodeRunning && $past(nodeRunning) |-> $stable(bitRate); endproperty
    a_rate: assert property (p_rate) else $error("active rate changed");
    property p_rwe; nvmRateWe |=> !nvmRateWe; endproperty
    a_rwe: assert property (p_rwe) else $error("rate write not a pulse");
    property p_rdata; nvmRateWe |-> nvmRateData <= 4'h8; endproperty
    a_rdata: assert property (p_rdata) else $error("rate code out of range");
    property p_idrange; nvmIdWe
        |-> nvmIdData inside {[7'h01:7'h3F]} ##1 nodeNumber == $past(nvmIdData); endproperty
    a_idrange: assert property (p_idrange) else $error("node number not adopted");
    property p_leds; !nodeRunning |-> errorIndicator == busActiveIndicator
        && (!errorIndicator || runIndicator); endproperty
    a_leds: assert property (p_leds) else $error("indicators wrong");
    property p_erroff; nodeRunning |-> !errorIndicator; endproperty
    a_erroff: assert property (p_erroff) else $error("error indicator lit");
    property p_order; nodeRunning |=> nodeRunning; endproperty
    a_order: assert property (p_order) else $error("left normal operation");
    property p_rdy; rxReady |-> nodeRunning && !txValid; endproperty
    a_rdy: assert property (p_rdy) else $error("frame taken too early");
endmodule // cnsi_node_asserts

// ### cnsi_master_model.sv
`timescale 1ns/10ps

module cnsi_master_model (
    // Clock
    input wire logic core_clk,
    // Frames to the node
    output logic rxValid,
    input wire logic rxReady,
    output logic [10:0] rxCobId,
    output logic rxDataFlag,
    output logic [3:0] rxDlc,
    output logic [63:0] rxData,
    // Frames from the node
    input wire logic txValid,
    output logic txReady,
    input wire logic [10:0] txCobId,
    input wire logic [3:0] txDlc,
    input wire logic [63:0] txData
);
    int stall = 0;
    int waited = 0;
    int gotCount = 0;
    logic [10:0] gotCob;
    logic [3:0] gotDlc;
    logic [63:0] gotData;

    initial begin
        rxValid = 1'b0;
        rxCobId = 11'h000;
        rxDataFlag = 1'b0;
        rxDlc = 4'h0;
        rxData = 64'h0;
        txReady = 1'b0;
    end

    task automatic send(input logic [10:0] cob, input logic fl, input logic [63:0] d);
        @(posedge core_clk);
        rxValid <= 1'b1;
        rxCobId <= cob;
        rxDataFlag <= fl;
        rxDlc <= fl ? 4'h8 : 4'h0;
        rxData <= d;
        @(negedge core_clk);
        for (int i = 0; i < 50 && rxReady !== 1'b1; i++) @(negedge core_clk);
        @(posedge core_clk);
        rxValid <= 1'b0;
        // Released lines must not keep looking valid.
        rxCobId <= ~cob;
        rxData <= ~d;
    endtask

    always @(posedge core_clk) begin
        if (txValid && txReady) begin
            gotCob <= txCobId;
            gotDlc <= txDlc;
            gotData <= txData;
            gotCount <= gotCount + 1;
            txReady <= 1'b0;
            waited <= 0;
        end else if (txValid) begin
            waited <= waited + 1;
            txReady <= waited >= stall;
        end
    end
endmodule // cnsi_master_model

// ### cnsi_node_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module cnsi_node_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] addrSelector = 7'h00;
    logic nmtOperational = 1'b0;
    logic tempPdoReq = 1'b0;
    logic emcyReq = 1'b0;
    logic clkEn = 1'b1;
    logic [3:0] nvmBitRate = 4'h3;
    logic [6:0] nvmNodeNumber = 7'h05;
    logic [15:0] tempCentiC = 16'h0D3B, emcyCode = 16'h1234;
    logic rxValid, rxReady, rxDataFlag, txValid, txReady, txDataFlag, nodeRunning;
    logic nvmRateWe, nvmIdWe, errorIndicator, runIndicator, busActiveIndicator;
    logic [3:0] nvmRateData, rxDlc, txDlc, lastRate;
    logic [6:0] nvmIdData, nodeNumber, lastId;
    logic [10:0] rxCobId, txCobId;
    logic [63:0] rxData, txData;
    logic [15:0] txIdWord;
    cnsi_pkg::cnsi_rate_t bitRate;
    int n_fail = 0;
    int check_count = 0;
    int rateWrites = 0;
    int idWrites = 0;

    initial forever #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (nvmRateWe) begin
            lastRate <= nvmRateData;
            rateWrites <= rateWrites + 1;
        end
        if (nvmIdWe) begin
            lastId <= nvmIdData;
            idWrites <= idWrites + 1;
        end
    end

    cnsi_node #(.POWERUP_CYCLES(200), .SETUP_CYCLES(100), .BLINK_HALF_CYCLES(10)) cnsi_node_i (.*);

    cnsi_master_model master_i (.*);

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic [6:0] sel);
        @(posedge core_clk);
        rst_n <= 1'b0;
        addrSelector <= sel;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    // Two blink periods: any phase gives 20 lit.
    task automatic count_run(output int hi);
        hi = 0;
        repeat (40) begin
            @(negedge core_clk);
            hi += int'(runIndicator === 1'b1);
        end
    endtask

    task automatic setup(input logic [6:0] rs, input logic [6:0] ids);
        int n0;
        int hi;
        do_reset(7'h00);
        repeat (2) @(posedge core_clk);
        addrSelector <= rs;
        n0 = rateWrites;
        count_run(hi);
        `CHK(hi, 20)
        for (int i = 0; i < 150 && rateWrites == n0; i++) @(negedge core_clk);
        `CHK(lastRate, rs <= 7'h08 ? rs[3:0] : 4'h3)
        @(posedge core_clk);
        addrSelector <= ids;
        n0 = idWrites;
        @(negedge core_clk);
        `CHK({errorIndicator, busActiveIndicator}, 2'b00)
        count_run(hi);
        `CHK(hi, 20)
        for (int i = 0; i < 150 && nodeRunning !== 1'b1; i++) @(negedge core_clk);
        `CHK(nodeNumber, ids inside {[7'h01:7'h3F]} ? ids : 7'h05)
        @(negedge core_clk);
        `CHK(idWrites - n0, ids inside {[7'h01:7'h3F]} ? 1 : 0)
    endtask

    // nb < 0: no frame may come back.
    task automatic waitTx(input int n0, input logic [10:0] c, input logic [3:0] d,
                          input logic [63:0] v, input int nb);
        logic [63:0] m;
        m = (nb >= 8) ? '1 : (64'h1 << (8 * nb)) - 64'h1;
        for (int i = 0; i < 40 && master_i.gotCount == n0; i++) @(negedge core_clk);
        if (nb < 0) begin
            `CHK(master_i.gotCount, n0)
        end else begin
            `CHK(master_i.gotCob, c)
            `CHK(master_i.gotDlc, d)
            `CHK(master_i.gotData & m, v)
        end
    endtask

    task automatic xfer(input logic [10:0] cob, input logic fl, input logic [63:0] dat,
                        input logic [10:0] c, input logic [63:0] v, input int nb);
        int n0;
        n0 = master_i.gotCount;
        master_i.send(cob, fl, dat);
        waitTx(n0, c, nb == 1 ? 4'h1 : 4'h8, v, nb);
    endtask

    task automatic pulse(input bit emcy, output int n0);
        n0 = master_i.gotCount;
        @(posedge core_clk);
        if (emcy) emcyReq <= 1'b1;
        else tempPdoReq <= 1'b1;
        @(posedge core_clk);
        emcyReq <= 1'b0;
        tempPdoReq <= 1'b0;
    endtask

    initial begin
        int t;
        int n0;
        logic [3:0] br;
        do_reset(7'h11);
        t = 0;
        while (t < 400 && nodeRunning !== 1'b1) begin
            @(negedge core_clk);
            t++;
        end
        `CHK(t > 195, 1'b1)
        `CHK(bitRate, cnsi_pkg::CNSI_RATE_125K)
        `CHK(nodeNumber, 7'h05)
        for (int r = 0; r < 10; r++) setup(7'(r), r == 0 ? 7'h3F : r == 1 ? 7'h40 : 7'h02);
        br = bitRate;
        master_i.stall = 3;
        xfer(11'h602, 1'b1, 64'h0032_0040, 11'h582, 64'h0D3B_0032_004B, 8);
        master_i.stall = 0;
        xfer(11'h642, 1'b1, 64'h0032_0040, 11'h5C2, 64'h0D3B_0032_004B, 8);
        xfer(11'h602, 1'b1, 64'h0005_0020_012F, 11'h582, 64'h0020_0160, 8);
        `CHK(lastRate, 4'h5)
        `CHK(bitRate, br)
        xfer(11'h602, 1'b1, 64'h0009_0020_012F, 11'h582, 64'h0609_0030_0020_0180, 8);
        xfer(11'h602, 1'b1, 64'h0032_002F, 11'h582, 64'h0504_0001_0032_0080, 8);
        xfer(11'h602, 1'b1, 64'h0012_3440, 11'h582, 64'h0602_0000_0012_3480, 8);
        xfer(11'h702, 1'b0, 64'h0, 11'h702, 64'h7F, 1);
        xfer(11'h000, 1'b1, 64'h0201, 11'h0, 64'h0, -1);
        xfer(11'h080, 1'b1, 64'h0, 11'h0, 64'h0, -1);
        xfer(11'h202, 1'b1, 64'h1, 11'h0, 64'h0, -1);
        pulse(1'b0, n0);
        waitTx(n0, 11'h0, 4'h0, 64'h0, -1);
        @(posedge core_clk);
        nmtOperational <= 1'b1;
        xfer(11'h702, 1'b0, 64'h0, 11'h702, 64'h05, 1);
        pulse(1'b0, n0);
        waitTx(n0, 11'h282, 4'h2, 64'h0D3B, 2);
        pulse(1'b1, n0);
        waitTx(n0, 11'h082, 4'h8, 64'h1234, 2);
        summarize();
    end

    initial begin
        #80000;
        n_fail++;
        summarize();
    end
endmodule // cnsi_node_tb

bind cnsi_node cnsi_node_asserts cnsi_node_asserts_i (.*);
